// file: logic/crsr_regs.vh
/*
 * Register offsets, field positions and reset values of the clock route
 * and status register block.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef CRSR_REGS_VH
`define CRSR_REGS_VH

`define CRSR_ADDR_W            10
`define CRSR_OFS_OUT_CTRL      10'h1ba
`define CRSR_OFS_ROUTING       10'h1bb
`define CRSR_OFS_CLK_READBACK  10'h22c
`define CRSR_OFS_HOLD_READBACK 10'h22d

`define CRSR_CTRL_SEL_HI       7
`define CRSR_CTRL_SEL_LO       5
`define CRSR_CTRL_WEAK_BIT     4
`define CRSR_CTRL_RATIO_HI     3
`define CRSR_CTRL_RATIO_LO     0

`define CRSR_ROUTE_PDN_BIT     7
`define CRSR_ROUTE_SEL_HI      6
`define CRSR_ROUTE_SEL_LO      4
`define CRSR_ROUTE_XTAL_HI     3
`define CRSR_ROUTE_XTAL_LO     0

`define CRSR_RATIO_DIV1        4'h0
`define CRSR_RATIO_DIV2        4'h1
`define CRSR_RATIO_DIV4        4'h2
`define CRSR_RATIO_DIV8        4'h4
`define CRSR_RATIO_DIV16       4'h8

`define CRSR_OUT_CTRL_RESET    8'h01
`define CRSR_ROUTING_RESET     8'h00

`define CRSR_HOLD_BIT          3
`define CRSR_AUTOSEL_BIT       2
`define CRSR_CAL_BIT           0

`endif

// file: logic/crsr_clock_route.v
/*
 * Clock route and status registers of the clock generator.
 * Holds two control bytes that steer the channel prescaler sources,
 * the crystal routing of the low channels and the buffered input-loop
 * output, and two readback bytes of clock presence, loop lock,
 * holdover, automatic reference choice and calibration.
 *
 * Assumes the serial control port ahead of this block turns its
 * transfers into single-byte accesses, each a one-cycle strobe with
 * stable address and data, and that every status input is already
 * synchronous to clock. Writes and reads are single bytes; there is
 * no burst or address increment at this level. The dividers and
 * drivers that consume the outputs sit outside this block and do
 * their own glitch-free switching.
 */
`timescale 1ns/100ps
`include "crsr_regs.vh"

module crsr_clock_route (
    input  wire                    clock,
    input  wire                    sys_rst,
    input  wire [`CRSR_ADDR_W-1:0] regAddr,
    input  wire                    regWrite,
    input  wire [7:0]              regWriteData,
    input  wire                    regRead,
    input  wire                    outputLoopRefOk,
    input  wire                    outputLoopFbOk,
    input  wire                    crystalClockOk,
    input  wire                    testRefOk,
    input  wire                    secondRefOk,
    input  wire                    firstRefOk,
    input  wire                    outputLoopLocked,
    input  wire                    inputLoopLocked,
    input  wire                    holdoverActive,
    input  wire                    autoSelSecondRef,
    input  wire                    calibrationBusy,
    output reg  [7:0]              regReadData,
    output reg                     regReadValid,
    output reg  [9:4]              channelPrescalerSelect,
    output reg  [3:0]              crystalToChannel,
    output reg  [3:0]              bufferedOutRatio,
    output reg                     bufferedOutWeakDrive,
    output reg                     bufferedOutPowerDown
);

    // Reset values, split per field below
    localparam [7:0]        CTRL_RESET  = `CRSR_OUT_CTRL_RESET;
    localparam [7:0]        ROUTE_RESET = `CRSR_ROUTING_RESET;

    // Each control field in its own register
    reg  [2:0]              ctrlSelect_q;
    reg                     ctrlWeak_q;
    reg  [3:0]              ratio_q;
    reg                     routePowerDown_q;
    reg  [2:0]              routeSelect_q;
    reg  [3:0]              routeCrystal_q;

    // Status bytes, one cycle behind the pins
    reg  [7:0]              clkStatus_q;
    reg  [7:0]              holdStatus_q;

    // Combinational helpers
    reg  [7:0]              readData_d;
    reg                     ratioLegal;
    wire [3:0]              newRatio;
    wire [7:0]              outCtrl;
    wire [7:0]              routing;

    wire                    hitOutCtrl;
    wire                    hitRouting;
    wire                    hitClkReadback;
    wire                    hitHoldReadback;
    wire                    wrOutCtrl;
    wire                    wrRouting;

    wire [7:0]              clkStatus_d;
    wire [7:0]              holdStatus_d;
    wire [9:4]              channelPrescalerSelect_d;
    wire [3:0]              crystalToChannel_d;
    wire [3:0]              bufferedOutRatio_d;
    wire                    bufferedOutWeakDrive_d;
    wire                    bufferedOutPowerDown_d;

    genvar                  chan;

    // Address decode
    assign hitOutCtrl      = (regAddr == `CRSR_OFS_OUT_CTRL);
    assign hitRouting      = (regAddr == `CRSR_OFS_ROUTING);
    assign hitClkReadback  = (regAddr == `CRSR_OFS_CLK_READBACK);
    assign hitHoldReadback = (regAddr == `CRSR_OFS_HOLD_READBACK);

    // Readback addresses get no write strobe at all
    assign wrOutCtrl       = regWrite & hitOutCtrl;
    assign wrRouting       = regWrite & hitRouting;

    // Whole bytes as software sees them
    assign outCtrl = {ctrlSelect_q, ctrlWeak_q, ratio_q};
    assign routing = {routePowerDown_q, routeSelect_q, routeCrystal_q};

    assign newRatio = regWriteData[`CRSR_CTRL_RATIO_HI:`CRSR_CTRL_RATIO_LO];

    // Only zero and the four one-hot codes are legal ratios
    always @* begin
        case (newRatio)
            `CRSR_RATIO_DIV1,
            `CRSR_RATIO_DIV2,
            `CRSR_RATIO_DIV4,
            `CRSR_RATIO_DIV8,
            `CRSR_RATIO_DIV16: ratioLegal = 1'b1;
            default:           ratioLegal = 1'b0;
        endcase
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlSelect_q <= CTRL_RESET[`CRSR_CTRL_SEL_HI:`CRSR_CTRL_SEL_LO];
        end else if (wrOutCtrl) begin
            ctrlSelect_q <= regWriteData[`CRSR_CTRL_SEL_HI:`CRSR_CTRL_SEL_LO];
        end
    end

    // One gives weak drive, zero strong
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrlWeak_q <= CTRL_RESET[`CRSR_CTRL_WEAK_BIT];
        end else if (wrOutCtrl) begin
            ctrlWeak_q <= regWriteData[`CRSR_CTRL_WEAK_BIT];
        end
    end

    // A forbidden code leaves the old ratio, the rest of the byte still lands
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ratio_q <= CTRL_RESET[`CRSR_CTRL_RATIO_HI:`CRSR_CTRL_RATIO_LO];
        end else if (wrOutCtrl && ratioLegal) begin
            ratio_q <= newRatio;
        end
    end

    // Power-down stops only the driver; the ratio is kept
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            routePowerDown_q <= ROUTE_RESET[`CRSR_ROUTE_PDN_BIT];
        end else if (wrRouting) begin
            routePowerDown_q <= regWriteData[`CRSR_ROUTE_PDN_BIT];
        end
    end

    // Routing byte fields
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            routeSelect_q <= ROUTE_RESET[`CRSR_ROUTE_SEL_HI:`CRSR_ROUTE_SEL_LO];
        end else if (wrRouting) begin
            routeSelect_q <= regWriteData[`CRSR_ROUTE_SEL_HI:`CRSR_ROUTE_SEL_LO];
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            routeCrystal_q <= ROUTE_RESET[`CRSR_ROUTE_XTAL_HI:`CRSR_ROUTE_XTAL_LO];
        end else if (wrRouting) begin
            routeCrystal_q <= regWriteData[`CRSR_ROUTE_XTAL_HI:`CRSR_ROUTE_XTAL_LO];
        end
    end

    // Pin order matches the readback bit order
    assign clkStatus_d = {outputLoopRefOk, outputLoopFbOk, crystalClockOk, testRefOk,
                          secondRefOk, firstRefOk, outputLoopLocked, inputLoopLocked};

    // Reserved bits tied low so they read zero
    assign holdStatus_d[7:4]               = 4'h0;
    assign holdStatus_d[`CRSR_HOLD_BIT]    = holdoverActive;
    assign holdStatus_d[`CRSR_AUTOSEL_BIT] = autoSelSecondRef;
    assign holdStatus_d[1]                 = 1'b0;
    assign holdStatus_d[`CRSR_CAL_BIT]     = calibrationBusy;

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            clkStatus_q <= 8'h00;
        end else begin
            clkStatus_q <= clkStatus_d;
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            holdStatus_q <= 8'h00;
        end else begin
            holdStatus_q <= holdStatus_d;
        end
    end

    // Zero picks the first prescaler, one the second
    generate
        for (chan = 4; chan <= 9; chan = chan + 1) begin : g_chan_sel
            if (chan <= 6) begin : g_ctrl_byte
                // Channels 4 to 6 sit in the control byte
                assign channelPrescalerSelect_d[chan] = outCtrl[`CRSR_CTRL_SEL_LO + chan - 4];
            end else begin : g_route_byte
                // Channels 7 to 9 sit in the routing byte
                assign channelPrescalerSelect_d[chan] = routing[`CRSR_ROUTE_SEL_LO + chan - 7];
            end
        end
    endgenerate

    // Low channels may take the crystal clock instead
    generate
        for (chan = 0; chan < 4; chan = chan + 1) begin : g_chan_xtal
            assign crystalToChannel_d[chan] = routing[`CRSR_ROUTE_XTAL_LO + chan];
        end
    endgenerate

    // Buffered output controls
    assign bufferedOutRatio_d     = outCtrl[`CRSR_CTRL_RATIO_HI:`CRSR_CTRL_RATIO_LO];
    assign bufferedOutWeakDrive_d = outCtrl[`CRSR_CTRL_WEAK_BIT];
    assign bufferedOutPowerDown_d = routing[`CRSR_ROUTE_PDN_BIT];

    // Read data is chosen from the address of the strobe
    always @* begin
        case (1'b1)
            hitOutCtrl:      readData_d = outCtrl;
            hitRouting:      readData_d = routing;
            hitClkReadback:  readData_d = clkStatus_q;
            hitHoldReadback: readData_d = holdStatus_q;
            // Unmapped reads return zero
            default:         readData_d = 8'h00;
        endcase
    end

    // Every output straight from its own flop
    // One-cycle pulse for each read strobe
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= regRead;
        end
    end

    // Read data holds until the next read
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            regReadData <= 8'h00;
        end else if (regRead) begin
            regReadData <= readData_d;
        end
    end

    // Selects follow the stored field one cycle later
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            channelPrescalerSelect <= 6'h00;
        end else begin
            channelPrescalerSelect <= channelPrescalerSelect_d;
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            crystalToChannel <= 4'h0;
        end else begin
            crystalToChannel <= crystalToChannel_d;
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bufferedOutRatio <= `CRSR_RATIO_DIV2;
        end else begin
            bufferedOutRatio <= bufferedOutRatio_d;
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bufferedOutWeakDrive <= 1'b0;
        end else begin
            bufferedOutWeakDrive <= bufferedOutWeakDrive_d;
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bufferedOutPowerDown <= 1'b0;
        end else begin
            bufferedOutPowerDown <= bufferedOutPowerDown_d;
        end
    end

endmodule // crsr_clock_route

// file: verif/crsr_route_checker.sv
/* Assertions on the register port and control outputs of crsr_clock_route.
   Assumes one clock domain and binding to the design top. */
`timescale 1ns/100ps
`include "crsr_regs.vh"
module crsr_route_checker (
    input logic                    clock, sys_rst, regWrite, regRead, regReadValid, bufferedOutWeakDrive,
    input logic                    bufferedOutPowerDown, holdoverActive, calibrationBusy,
    input logic [`CRSR_ADDR_W-1:0] regAddr,
    input logic [7:0]              regWriteData, regReadData,
    input logic [9:4]              channelPrescalerSelect,
    input logic [3:0]              crystalToChannel, bufferedOutRatio
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire wrCtrl = regWrite && regAddr == `CRSR_OFS_OUT_CTRL;
    wire wrRoute = regWrite && regAddr == `CRSR_OFS_ROUTING;
    wire rdHold = regRead && regAddr == `CRSR_OFS_HOLD_READBACK;
    property p_sel_lo; wrCtrl |-> ##2 channelPrescalerSelect[6:4] == $past(regWriteData[7:5], 2); endproperty
    a_sel_lo: assert property (p_sel_lo) else $error("low select wrong");
    property p_sel_hi; wrRoute |-> ##2 channelPrescalerSelect[9:7] == $past(regWriteData[6:4], 2); endproperty
    a_sel_hi: assert property (p_sel_hi) else $error("high select wrong");
    property p_ratio; wrCtrl && $onehot0(regWriteData[3:0]) |->
        ##2 bufferedOutRatio == $past(regWriteData[3:0], 2); endproperty
    a_ratio: assert property (p_ratio) else $error("ratio wrong");
    property p_ratio_ok; $onehot0(bufferedOutRatio); endproperty
    a_ratio_ok: assert property (p_ratio_ok) else $error("ratio code illegal");
    property p_weak; wrCtrl |-> ##2 bufferedOutWeakDrive == $past(regWriteData[4], 2); endproperty
    a_weak: assert property (p_weak) else $error("drive wrong");
    property p_pdn; wrRoute |-> ##2 bufferedOutPowerDown == $past(regWriteData[7], 2); endproperty
    a_pdn: assert property (p_pdn) else $error("power-down wrong");
    property p_xtal; wrRoute |-> ##2 crystalToChannel == $past(regWriteData[3:0], 2); endproperty
    a_xtal: assert property (p_xtal) else $error("crystal route wrong");
    property p_rdv; regReadValid |-> $past(regRead); endproperty
    a_rdv: assert property (p_rdv) else $error("stray read valid");
    property p_hold; rdHold && !$past(sys_rst) |=> regReadValid && regReadData[7:4] == 4'h0 && !regReadData[1]
        && regReadData[3] == $past(holdoverActive, 2) && regReadData[0] == $past(calibrationBusy, 2); endproperty
    a_hold: assert property (p_hold) else $error("holdover readback wrong");
    c_bad_ratio: cover property (wrCtrl && !$onehot0(regWriteData[3:0]));
    c_route: cover property (wrRoute);
    c_hold: cover property (rdHold);
endmodule // crsr_route_checker
bind crsr_clock_route crsr_route_checker u_chk (.clock, .sys_rst, .regWrite, .regRead, .regReadValid,
    .bufferedOutWeakDrive, .bufferedOutPowerDown, .holdoverActive, .calibrationBusy, .regAddr, .regWriteData,
    .regReadData, .channelPrescalerSelect, .crystalToChannel, .bufferedOutRatio);

// file: verif/crsr_clock_route_tb.sv
/* Bench for crsr_clock_route: register rows, reset values, status readback.
   Assumes the bound checker and the plain strobe register port. */
`timescale 1ns/100ps
module crsr_clock_route_tb;
    logic clock = 0, sys_rst = 1, regWrite = 0, regRead = 0, regReadValid, bufferedOutWeakDrive, bufferedOutPowerDown;
    logic [9:0] regAddr = 0;
    logic [7:0] regWriteData = 0, regReadData, c = 8'h01, t = 8'h00;
    logic [10:0] st = 0;
    logic [9:4] channelPrescalerSelect;
    logic [3:0] crystalToChannel, bufferedOutRatio;
    int miscompares = 0, n_checks = 0;
    // Address, written byte, expected readback; the e3 row carries an illegal ratio
    logic [25:0] rows [8] = '{{10'h1ba, 8'hf0, 8'hf0}, {10'h1ba, 8'h18, 8'h18}, {10'h1ba, 8'ha2, 8'ha2},
        {10'h1ba, 8'h54, 8'h54}, {10'h1ba, 8'h01, 8'h01}, {10'h1ba, 8'he3, 8'he1},
        {10'h1bb, 8'h8f, 8'h8f}, {10'h1bb, 8'h70, 8'h70}};
    always #25 clock = ~clock;
    crsr_clock_route dut (.clock, .sys_rst, .regAddr, .regWrite, .regWriteData, .regRead,
        .outputLoopRefOk(st[10]), .outputLoopFbOk(st[9]), .crystalClockOk(st[8]), .testRefOk(st[7]),
        .secondRefOk(st[6]), .firstRefOk(st[5]), .outputLoopLocked(st[4]), .inputLoopLocked(st[3]),
        .holdoverActive(st[2]), .autoSelSecondRef(st[1]), .calibrationBusy(st[0]), .regReadData, .regReadValid,
        .channelPrescalerSelect, .crystalToChannel, .bufferedOutRatio, .bufferedOutWeakDrive, .bufferedOutPowerDown);
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock); regAddr <= a; regWriteData <= d; regWrite <= 1;
        @(posedge clock); regWrite <= 0;
    endtask
    task rd(input logic [9:0] a, input logic [7:0] exp);
        @(posedge clock); regAddr <= a; regRead <= 1;
        @(posedge clock); regRead <= 0;
        #1 chk({7'h0, regReadValid}, 8'h01);
        chk(regReadData, exp);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clock);
        miscompares++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 0;
        rd(10'h1ba, 8'h01);
        rd(10'h1bb, 8'h00);
        foreach (rows[i]) begin
            if (rows[i][25:16] == 10'h1ba) c = rows[i][7:0];
            else t = rows[i][7:0];
            wr(rows[i][25:16], rows[i][15:8]);
            rd(rows[i][25:16], rows[i][7:0]);
            chk({channelPrescalerSelect[6:4], bufferedOutWeakDrive, bufferedOutRatio}, c);
            chk({bufferedOutPowerDown, channelPrescalerSelect[9:7], crystalToChannel}, t);
        end
        @(posedge clock);
        st <= 11'h5a6;
        wr(10'h22c, 8'hff);
        wr(10'h22d, 8'hff);
        wr(10'h300, 8'hff);
        rd(10'h22c, 8'hb4);
        rd(10'h22d, 8'h0c);
        @(posedge clock);
        st <= 11'h2f9;
        rd(10'h22c, 8'h5f);
        rd(10'h22d, 8'h01);
        rd(10'h300, 8'h00);
        rd(10'h1bb, t);
        end_sim;
    end
endmodule // crsr_clock_route_tb
